// File: include/mrz_cfg.svh
// How it works
// - Bits 1:0 pick burst length mode
// - On the fly, A12 picks chop
// - Bit 3 picks sequential or interleaved
// - Eight-beat read order rotates or XORs
// - Chop read: four words, then tri-state
// - Writes ignore low start column bits
// - Fixed chop write recovery two earlier
// - Bits 6,5,4,2 give CAS delay
// - First data after added plus CAS
// - Loop reset bit clears itself
// - Recovery plus precharge gives activate delay
// - Bit 12 low freezes loop, slow exit
// - Bit 12 high keeps loop, fast exit
// - Written only on all-low set command
// - Bits 11:9 give recovery cycles
// - Bit 8 requests loop reset
`ifndef MRZ_CFG_SVH
`define MRZ_CFG_SVH

`define MRZ_REG_W          16
`define MRZ_REG_RESET      16'h0000
`define MRZ_BL_LSB         0
`define MRZ_BL_MSB         1
`define MRZ_BT_BIT         3
`define MRZ_CL_LOW_BIT     2
`define MRZ_CL_LSB         4
`define MRZ_CL_MSB         6
`define MRZ_TEST_BIT       7
`define MRZ_DLL_RST_BIT    8
`define MRZ_WR_LSB         9
`define MRZ_WR_MSB         11
`define MRZ_PD_BIT         12
`define MRZ_OTF_BIT        12
`define MRZ_PIN_W          25
`define MRZ_BURST_BEATS    8
`define MRZ_CHOP_LAST_BEAT 3'h3
`define MRZ_FULL_LAST_BEAT 3'h7
`define MRZ_CL_BASE_LOW    5'h04
`define MRZ_CL_BASE_HIGH   5'h0c
`define MRZ_WR_DOUBLE_FROM 3'h5
`define MRZ_WR_BASE        5'h04
`define MRZ_LOCK_CK        10'h200
`define MRZ_NORMAL_EXIT_CK 5'h03
`define MRZ_SLOW_EXIT_CK   5'h0a

`endif

// File: include/mrz_pkg.sv
package mrz_pkg;

  typedef enum logic [1:0] {
    BURST_FIXED_EIGHT = 2'b00,
    BURST_ON_FLY      = 2'b01,
    BURST_FIXED_CHOP  = 2'b10,
    BURST_RESERVED    = 2'b11
  } burst_mode_t;

  typedef enum logic [1:0] {
    ENG_IDLE = 2'b00,
    ENG_WAIT = 2'b01,
    ENG_BEAT = 2'b10
  } engine_state_t;

endpackage : mrz_pkg

// File: hdl/mrz_beat_order.sv
`timescale 1ns/100ps
`include "mrz_cfg.svh"
module mrz_beat_order (
  input  wire logic [2:0] beatIdx,
  input  wire logic [2:0] startCol,
  input  wire logic       interleaveOn,
  input  wire logic       chopOn,
  input  wire logic       isWrite,
  output logic      [2:0] wordIdx,
  output logic            slotLive
);
  logic [2:0] effCol;

  always_comb begin
    effCol = startCol;
    if (isWrite) begin
      effCol = chopOn ? {startCol[2], 2'b00} : 3'b000;
    end
    if (interleaveOn) begin
      wordIdx = effCol ^ beatIdx;
    end else begin
      wordIdx = {effCol[2] ^ beatIdx[2], effCol[1:0] + beatIdx[1:0]};
    end
    slotLive = !(chopOn && beatIdx[2]);
  end

endmodule : mrz_beat_order

// File: hdl/mrz_mode_reg_zero.sv
`timescale 1ns/100ps
`include "mrz_cfg.svh"
module mrz_mode_reg_zero (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                ckPin,
  input  wire logic                ckeIn,
  input  wire logic                chipSelN,
  input  wire logic                rowStrobeN,
  input  wire logic                colStrobeN,
  input  wire logic                writeEnN,
  input  wire logic [2:0]          bankSel,
  input  wire logic [15:0]         addrIn,
  input  wire logic [4:0]          addedLatency,
  input  wire logic [4:0]          writeCasDelay,
  input  wire logic [4:0]          prechargeTime,
  output logic      [15:0]         burstLatencyConfigReg,
  output mrz_pkg::burst_mode_t     burstBeats,
  output logic                     interleaveOn,
  output logic      [4:0]          readCasDelay,
  output logic      [5:0]          totalReadDelay,
  output logic      [4:0]          writeRecoveryCycles,
  output logic      [5:0]          writeToActivateDelay,
  output logic                     reservedCode,
  output logic                     testModeOn,
  output logic                     dllResetPulse,
  output logic                     dllLocked,
  output logic                     dllFrozen,
  output logic                     cmdReady,
  output logic                     dqOutEn,
  output logic      [2:0]          readWordIdx,
  output logic                     writeTake,
  output logic      [2:0]          writeWordIdx,
  output logic                     writeRecoveryStart
);
  import mrz_pkg::*;

  // CAS delay code {A6,A5,A4,A2}; zero marks a reserved code
  function automatic logic [4:0] decodeCas(input logic [3:0] code);
    logic [4:0] res;
    res = 5'h00;
    if (!code[0] && code[3:1] != 3'b000) begin
      res = `MRZ_CL_BASE_LOW + {2'b00, code[3:1]};
    end else if (code[0] && code[3:1] <= 3'b010) begin
      res = `MRZ_CL_BASE_HIGH + {2'b00, code[3:1]};
    end
    return res;
  endfunction : decodeCas

  // Recovery code {A11,A10,A9}; zero marks a reserved code
  function automatic logic [4:0] decodeRecovery(input logic [2:0] code);
    logic [4:0] res;
    res = 5'h00;
    if (code >= `MRZ_WR_DOUBLE_FROM) begin
      res = {1'b0, code, 1'b0};
    end else if (code != 3'b000) begin
      res = `MRZ_WR_BASE + {2'b00, code};
    end
    return res;
  endfunction : decodeRecovery

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [`MRZ_PIN_W-1:0] pinMeta_q;
  logic [`MRZ_PIN_W-1:0] pinSync_q;
  logic                  ckPrev_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pinMeta_q <= '0;
      pinSync_q <= '0;
    end else begin
      pinMeta_q <= {ckPin, ckeIn, chipSelN, rowStrobeN, colStrobeN, writeEnN,
                    bankSel, addrIn};
      pinSync_q <= pinMeta_q;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ckPrev_q <= 1'b0;
    end else begin
      ckPrev_q <= pinSync_q[24];
    end
  end

  logic        sCk;
  logic        sCke;
  logic        sCsN;
  logic        sRasN;
  logic        sCasN;
  logic        sWeN;
  logic [2:0]  sBank;
  logic [15:0] sAddr;
  logic        ckRise;
  logic        ckEdge;
  logic        cmdMrsZero;
  logic        cmdRead;
  logic        cmdWrite;

  assign {sCk, sCke, sCsN, sRasN, sCasN, sWeN, sBank, sAddr} = pinSync_q;
  assign ckRise = sCk && !ckPrev_q;
  assign ckEdge = sCk != ckPrev_q;
  assign cmdMrsZero = ckRise && sCke && !sCsN && !sRasN && !sCasN && !sWeN &&
                      sBank == 3'b000;
  assign cmdRead  = ckRise && sCke && !sCsN && sRasN && !sCasN && sWeN;
  assign cmdWrite = ckRise && sCke && !sCsN && sRasN && !sCasN && !sWeN;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration register
  logic [15:0] cfg_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_q <= `MRZ_REG_RESET;
    end else if (cmdMrsZero) begin
      // New write wins over the self-clear in the same cycle
      cfg_q <= sAddr;
    end else if (cfg_q[`MRZ_DLL_RST_BIT]) begin
      cfg_q[`MRZ_DLL_RST_BIT] <= 1'b0;
    end
  end

  burst_mode_t modeNow;
  logic [4:0]  casNow;
  logic [4:0]  recNow;
  logic [5:0]  readDelayNow;

  assign modeNow = burst_mode_t'(cfg_q[`MRZ_BL_MSB:`MRZ_BL_LSB]);
  assign casNow = decodeCas({cfg_q[`MRZ_CL_MSB:`MRZ_CL_LSB], cfg_q[`MRZ_CL_LOW_BIT]});
  assign recNow = decodeRecovery(cfg_q[`MRZ_WR_MSB:`MRZ_WR_LSB]);
  assign readDelayNow = {1'b0, addedLatency} + {1'b0, casNow};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      burstLatencyConfigReg <= `MRZ_REG_RESET;
      burstBeats            <= BURST_FIXED_EIGHT;
      interleaveOn          <= 1'b0;
      readCasDelay          <= 5'h00;
      totalReadDelay        <= 6'h00;
      writeRecoveryCycles   <= 5'h00;
      writeToActivateDelay  <= 6'h00;
      // Cleared register holds reserved codes, so flag them from reset on
      reservedCode          <= 1'b1;
      testModeOn            <= 1'b0;
    end else begin
      burstLatencyConfigReg <= cfg_q;
      burstBeats            <= modeNow;
      interleaveOn          <= cfg_q[`MRZ_BT_BIT];
      readCasDelay          <= casNow;
      totalReadDelay        <= readDelayNow;
      writeRecoveryCycles   <= recNow;
      writeToActivateDelay  <= {1'b0, recNow} + {1'b0, prechargeTime};
      reservedCode          <= modeNow == BURST_RESERVED || casNow == 5'h00 ||
                               recNow == 5'h00;
      testModeOn            <= cfg_q[`MRZ_TEST_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Loop reset and lock timer, counted in link clock rises
  logic [9:0] lockCnt_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dllResetPulse <= 1'b0;
      lockCnt_q     <= 10'h000;
      dllLocked     <= 1'b0;
    end else begin
      dllResetPulse <= cfg_q[`MRZ_DLL_RST_BIT];
      if (cfg_q[`MRZ_DLL_RST_BIT]) begin
        lockCnt_q <= 10'h000;
        dllLocked <= 1'b0;
      end else if (ckRise && !dllLocked) begin
        lockCnt_q <= lockCnt_q + 10'h001;
        dllLocked <= lockCnt_q == `MRZ_LOCK_CK - 10'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Precharge power-down
  logic       pdActive_q;
  logic [4:0] exitCnt_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pdActive_q <= 1'b0;
      exitCnt_q  <= 5'h00;
    end else if (ckRise) begin
      pdActive_q <= !sCke;
      if (pdActive_q && sCke) begin
        exitCnt_q <= cfg_q[`MRZ_PD_BIT] ? `MRZ_NORMAL_EXIT_CK : `MRZ_SLOW_EXIT_CK;
      end else if (exitCnt_q != 5'h00) begin
        exitCnt_q <= exitCnt_q - 5'h01;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dllFrozen <= 1'b0;
      cmdReady  <= 1'b0;
    end else begin
      dllFrozen <= pdActive_q && !cfg_q[`MRZ_PD_BIT];
      cmdReady  <= !pdActive_q && exitCnt_q == 5'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Burst engine: one burst at a time, commands while busy are dropped
  engine_state_t state_q;
  logic [5:0]    latCnt_q;
  logic [2:0]    beat_q;
  logic [2:0]    col_q;
  logic          isWr_q;
  logic          chop_q;
  logic          fixedChop_q;
  logic [2:0]    wordIdx;
  logic          slotLive;
  logic          otfChop;

  assign otfChop = modeNow == BURST_ON_FLY && !sAddr[`MRZ_OTF_BIT];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q     <= ENG_IDLE;
      latCnt_q    <= 6'h00;
      beat_q      <= 3'h0;
      col_q       <= 3'h0;
      isWr_q      <= 1'b0;
      chop_q      <= 1'b0;
      fixedChop_q <= 1'b0;
    end else begin
      unique case (state_q)
        ENG_IDLE: begin
          if (cmdRead || cmdWrite) begin
            state_q     <= ENG_WAIT;
            latCnt_q    <= cmdWrite ? {1'b0, addedLatency} + {1'b0, writeCasDelay}
                                    : readDelayNow;
            col_q       <= sAddr[2:0];
            isWr_q      <= cmdWrite;
            chop_q      <= modeNow == BURST_FIXED_CHOP || otfChop;
            fixedChop_q <= modeNow == BURST_FIXED_CHOP;
          end
        end
        ENG_WAIT: begin
          if (ckRise) begin
            if (latCnt_q <= 6'h01) begin
              state_q <= ENG_BEAT;
              beat_q  <= 3'h0;
            end else begin
              latCnt_q <= latCnt_q - 6'h01;
            end
          end
        end
        ENG_BEAT: begin
          if (ckEdge) begin
            beat_q <= beat_q + 3'h1;
            if (beat_q == `MRZ_FULL_LAST_BEAT) begin
              state_q <= ENG_IDLE;
            end
          end
        end
        default: state_q <= ENG_IDLE;
      endcase
    end
  end

  mrz_beat_order u_order (
    .beatIdx      (beat_q),
    .startCol     (col_q),
    .interleaveOn (cfg_q[`MRZ_BT_BIT]),
    .chopOn       (chop_q),
    .isWrite      (isWr_q),
    .wordIdx      (wordIdx),
    .slotLive     (slotLive)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dqOutEn            <= 1'b0;
      readWordIdx        <= 3'h0;
      writeTake          <= 1'b0;
      writeWordIdx       <= 3'h0;
      writeRecoveryStart <= 1'b0;
    end else begin
      dqOutEn      <= state_q == ENG_BEAT && !isWr_q && slotLive;
      readWordIdx  <= wordIdx;
      writeTake    <= state_q == ENG_BEAT && isWr_q && slotLive;
      writeWordIdx <= wordIdx;
      writeRecoveryStart <= state_q == ENG_BEAT && isWr_q && ckEdge &&
                            beat_q == (fixedChop_q ? `MRZ_CHOP_LAST_BEAT
                                                   : `MRZ_FULL_LAST_BEAT);
    end
  end

endmodule : mrz_mode_reg_zero

// File: bench/mrz_properties.sv
`timescale 1ns/100ps
module mrz_properties
  import mrz_pkg::*;
(
  input wire logic         clk,
  input wire logic         rst,
  input wire logic [15:0]  burstLatencyConfigReg,
  input wire burst_mode_t  burstBeats,
  input wire logic [4:0]   readCasDelay,
  input wire logic [4:0]   writeRecoveryCycles,
  input wire logic         reservedCode,
  input wire logic         interleaveOn,
  input wire logic         dllResetPulse,
  input wire logic         dllLocked,
  input wire logic         dllFrozen,
  input wire logic         cmdReady,
  input wire logic         dqOutEn,
  input wire logic [2:0]   readWordIdx,
  input wire logic         writeTake,
  input wire logic [2:0]   writeWordIdx,
  input wire logic         writeRecoveryStart
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////
  chk_pulse_once: assert property (dllResetPulse |=> !dllResetPulse)
    else $error("loop reset pulse longer than one cycle");
  chk_lock_drop: assert property (dllResetPulse |-> !dllLocked)
    else $error("lock kept through loop reset");
  chk_freeze_slow: assert property (dllFrozen |-> !burstLatencyConfigReg[12] && !cmdReady)
    else $error("loop frozen with fast exit or ready");
  chk_cas_range: assert property (!reservedCode |-> readCasDelay inside {[5'h05:5'h0e]})
    else $error("CAS delay out of range");
  chk_wr_range: assert property (!reservedCode |->
      writeRecoveryCycles inside {5'h05, 5'h06, 5'h07, 5'h08, 5'h0a, 5'h0c, 5'h0e})
    else $error("recovery cycles out of range");
  chk_seq_step: assert property ($changed(readWordIdx) && dqOutEn && $past(dqOutEn) && !interleaveOn
      |-> readWordIdx[1:0] == $past(readWordIdx[1:0]) + 2'h1)
    else $error("sequential order step wrong");
  chk_live_span: assert property ($rose(dqOutEn) |-> dqOutEn [*8])
    else $error("read beat too short");
  chk_chop_quiet: assert property (burstBeats == BURST_FIXED_CHOP && $fell(dqOutEn)
      |-> !dqOutEn [*8])
    else $error("chop slots driven");
  chk_eight_write: assert property ($rose(writeTake) && burstBeats == BURST_FIXED_EIGHT
      |-> writeWordIdx == 3'h0)
    else $error("eight-beat write not from word zero");
  chk_rec_pulse: assert property (writeRecoveryStart |=> !writeRecoveryStart)
    else $error("recovery start pulse too long");
endmodule : mrz_properties

bind mrz_mode_reg_zero mrz_properties mrz_properties_inst (.*);

// File: bench/mrz_ctrl_model.sv
`timescale 1ns/100ps
module mrz_ctrl_model (
  output logic        ckPin,
  output logic        ckeIn,
  output logic        chipSelN,
  output logic        rowStrobeN,
  output logic        colStrobeN,
  output logic        writeEnN,
  output logic [2:0]  bankSel,
  output logic [15:0] addrIn
);
  time tCmd;
  initial begin
    ckPin = 1'b0;
    ckeIn = 1'b1;
    chipSelN = 1'b1;
    {rowStrobeN, colStrobeN, writeEnN} = 3'b111;
    bankSel = 3'b000;
    addrIn = 16'h0000;
    // Offset so link edges never meet system clock edges
    #7;
    forever #160 ckPin = ~ckPin;
  end
  ////////////////////////////////////////////////////////////////
  // Held falling to falling; released bank and address pins show inverted values
  task automatic issue(input logic [2:0] rcw, input logic [2:0] bank, input logic [15:0] addr);
    @(negedge ckPin);
    chipSelN = 1'b0;
    {rowStrobeN, colStrobeN, writeEnN} = rcw;
    bankSel = bank;
    addrIn = addr;
    @(posedge ckPin);
    tCmd = $time;
    @(negedge ckPin);
    chipSelN = 1'b1;
    {rowStrobeN, colStrobeN, writeEnN} = 3'b111;
    bankSel = ~bank;
    addrIn = ~addr;
  endtask : issue
  // whole word, test bit and reserved bits zero
  task automatic mode_reg_set_cmd(input logic [15:0] v, input logic [2:0] bank);
    issue(3'b000, bank, {3'b000, v[12:8], 1'b0, v[6:0]});
  endtask : mode_reg_set_cmd
  // bit 12 picks chop per command
  task automatic cmd(input logic isWr, input logic [2:0] col, input logic a12);
    issue(isWr ? 3'b100 : 3'b101, 3'b000, {3'b000, a12, 9'h000, col});
  endtask : cmd
  task automatic sleep(input int n);
    @(negedge ckPin);
    ckeIn = 1'b0;
    repeat (n) @(negedge ckPin);
    ckeIn = 1'b1;
  endtask : sleep
endmodule : mrz_ctrl_model

// File: bench/sdram_mode_register_zero_bench.sv
`timescale 1ns/100ps
module sdram_mode_register_zero_bench;
  import mrz_pkg::*;
  logic clk = 1'b0, rst = 1'b1;
  logic ckPin, ckeIn, chipSelN, rowStrobeN, colStrobeN, writeEnN;
  logic [2:0] bankSel, readWordIdx, writeWordIdx;
  logic [15:0] addrIn, burstLatencyConfigReg;
  logic [4:0] addedLatency = 5'h00, writeCasDelay = 5'h05, prechargeTime = 5'h00;
  logic [4:0] readCasDelay, writeRecoveryCycles;
  logic [5:0] totalReadDelay, writeToActivateDelay;
  burst_mode_t burstBeats;
  logic interleaveOn, reservedCode, testModeOn, dllResetPulse, dllLocked, dllFrozen;
  logic cmdReady, dqOutEn, writeTake, writeRecoveryStart, live, liveQ;
  logic [2:0] word, wordQ;
  logic [2:0] q[$];
  int error_cnt = 0, samples_checked = 0, pulses = 0, p0, cnt;
  time tFirst, tRec;
  logic [15:0] v;
  always #20 clk = ~clk;
  mrz_ctrl_model ctrl_inst (.*);
  mrz_mode_reg_zero mrz_mode_reg_zero_inst (.*);
  ////////////////////////////////////////////////////////////////
  // Sample away from the launching edge to avoid racing the design
  always @(negedge clk) begin
    live = dqOutEn | writeTake;
    word = dqOutEn ? readWordIdx : writeWordIdx;
    if (live === 1'b1 && (liveQ !== 1'b1 || word !== wordQ)) begin
      q.push_back(word);
      if (tFirst == 0) tFirst = $time;
    end
    if (writeRecoveryStart === 1'b1) tRec = $time;
    if (dllResetPulse === 1'b1) pulses++;
    liveQ = live;
    wordQ = word;
  end
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t value got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic cmp_in(input longint got, input longint lo, input longint hi);
    samples_checked++;
    if (got < lo || got > hi) begin
      error_cnt++;
      $display("MISMATCH %0t timing %0d not in %0d..%0d", $time, got, lo, hi);
    end
  endtask : cmp_in
  function automatic logic [4:0] exp_cas(input logic [15:0] x);
    if (!x[2]) return (x[6:4] == 3'h0) ? 5'h00 : 5'h04 + {2'b00, x[6:4]};
    return (x[6:4] <= 3'h2) ? 5'h0c + {2'b00, x[6:4]} : 5'h00;
  endfunction : exp_cas
  function automatic logic [4:0] exp_wr(input logic [15:0] x);
    if (x[11:9] == 3'h0) return 5'h00;
    return (x[11:9] < 3'h5) ? 5'h04 + {2'b00, x[11:9]} : {1'b0, x[11:9], 1'b0};
  endfunction : exp_wr
  task automatic cfg(input logic [15:0] x);
    logic res;
    p0 = pulses;
    ctrl_inst.mode_reg_set_cmd(x, 3'b000);
    repeat (3) @(posedge clk);
    res = (x[1:0] == 2'b11) || exp_cas(x) == 5'h00 || exp_wr(x) == 5'h00;
    cmp(burstLatencyConfigReg, {3'b000, x[12:9], 2'b00, x[6:0]});
    cmp(16'(pulses - p0), {15'h0000, x[8]});
    cmp(16'(burstBeats), {14'h0000, x[1:0]});
    cmp(16'(interleaveOn), {15'h0000, x[3]});
    cmp(16'(readCasDelay), 16'(exp_cas(x)));
    cmp(16'(writeRecoveryCycles), 16'(exp_wr(x)));
    cmp(16'(reservedCode), 16'(res));
    cmp(16'(testModeOn), 16'h0000);
    if (!res) cmp(16'(totalReadDelay), 16'(addedLatency) + 16'(exp_cas(x)));
    if (!res) cmp(16'(writeToActivateDelay), 16'(exp_wr(x)) + 16'(prechargeTime));
  endtask : cfg
  task automatic burst(input logic isWr, input logic [2:0] c, input logic a12, input logic [15:0] x);
    logic chop;
    longint lat;
    int n;
    chop = (x[1:0] == 2'b10) || (x[1:0] == 2'b01 && !a12);
    n = chop ? 4 : 8;
    lat = isWr ? addedLatency + writeCasDelay : addedLatency + exp_cas(x);
    q.delete();
    tFirst = 0;
    tRec = 0;
    ctrl_inst.cmd(isWr, c, a12);
    for (int k = 0; k < 3000 && q.size() < n; k++) @(posedge clk);
    repeat (40) @(posedge clk);
    cmp(16'(q.size()), 16'(n));
    for (int b = 0; b < n; b++)
      cmp(16'(q[b]), isWr ? 16'(chop ? {c[2], 2'(b)} : 3'(b)) : x[3] ? 16'(c ^ 3'(b))
        : 16'({c[2] ^ 3'(b) >> 2, c[1:0] + 2'(b)}));
    cmp_in(tFirst - ctrl_inst.tCmd, lat * 320, lat * 320 + 240);
    if (isWr) cmp_in(tRec - tFirst, (x[1:0] == 2'b10 ? 4 : 8) * 160 - 80,
      (x[1:0] == 2'b10 ? 4 : 8) * 160 + 80);
  endtask : burst
  task print_verdict;
    if (error_cnt == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  ////////////////////////////////////////////////////////////////
  initial begin
    #900000;
    error_cnt++;
    print_verdict;
  end
  initial begin
    void'($urandom(6772));
    repeat (16) @(posedge clk);
    #2 rst = 1'b0;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 16; i++) begin
      @(posedge clk) #2;
      addedLatency = 5'($urandom_range(0, 3));
      prechargeTime = 5'($urandom_range(0, 31));
      v = 16'($urandom);
      v[1:0] = 2'(i);
      {v[6:4], v[2]} = 4'(i);
      v[11:9] = 3'(i);
      cfg(v);
    end
    ctrl_inst.mode_reg_set_cmd(16'h0000, 3'b001);
    repeat (3) @(posedge clk);
    cmp(burstLatencyConfigReg, {3'b000, v[12:9], 2'b00, v[6:0]});
    cfg(16'h1324);
    cmp(16'(dllLocked), 16'h0000);
    repeat (4064) @(posedge clk);
    cmp(16'(dllLocked), 16'h0000);
    repeat (96) @(posedge clk);
    cmp(16'(dllLocked), 16'h0001);
    for (int j = 0; j < 12; j++) begin
      @(posedge clk) #2;
      writeCasDelay = 5'($urandom_range(5, 8));
      v = 16'($urandom) & 16'h1e7f;
      v[1:0] = 2'(j % 3);
      v[3] = j >= 6;
      v[6:4] = 3'($urandom_range(1, 7));
      v[2] = 1'b0;
      v[11:9] = 3'($urandom_range(1, 7));
      cfg(v);
      burst(j % 6 >= 3, 3'($urandom), 1'(j >> 2), v);
    end
    for (int s = 0; s < 2; s++) begin
      cfg({3'b000, 1'(s), 12'h224});
      ctrl_inst.sleep(3);
      cmp(16'(dllFrozen), 16'(s == 0));
      for (cnt = 0; cnt < 300 && cmdReady !== 1'b1; cnt++) @(posedge clk);
      cmp_in(cnt, (s ? 3 : 10) * 8, (s ? 3 : 10) * 8 + 16);
    end
    print_verdict;
  end
endmodule : sdram_mode_register_zero_bench
